// [verilog/pcrb_regs.svh]
// register offsets, field positions and reset values of the loop configuration bank
`ifndef PCRB_REGS_SVH
`define PCRB_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define PCRB_OFS_CTRL 10'h000
`define PCRB_OFS_TAG_LO 10'h005
`define PCRB_OFS_TAG_HI 10'h006
`define PCRB_OFS_LOOP 10'h010
`define PCRB_OFS_RDIV_LO 10'h011
`define PCRB_OFS_RDIV_HI 10'h012

// ----------------------------------------
// field positions
// ----------------------------------------
`define PCRB_SOFT_RESET_BIT 5
`define PCRB_POL_BIT 7
`define PCRB_CUR_MSB 6
`define PCRB_CUR_LSB 4
`define PCRB_PMODE_MSB 3
`define PCRB_PMODE_LSB 2
`define PCRB_LMODE_MSB 1
`define PCRB_LMODE_LSB 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PCRB_RST_TAG 8'h00
`define PCRB_RST_LOOP 8'h7D
`define PCRB_RST_RDIV_LO 8'h01
`define PCRB_RST_RDIV_HI 6'h00

`endif

// [verilog/pcrb_pkg.sv]
// types shared by the loop configuration bank
package pcrb_pkg;
   // loop operating modes
   typedef enum logic [1:0] {
      PCRB_LOOP_NORMAL = 2'h0,
      PCRB_LOOP_ASYNC_PD = 2'h1,
      PCRB_LOOP_UNUSED = 2'h2,
      PCRB_LOOP_SYNC_PD = 2'h3
   } pcrb_loop_mode_t;

   // charge pump modes
   typedef enum logic [1:0] {
      PCRB_PUMP_HIZ = 2'h0,
      PCRB_PUMP_SOURCE = 2'h1,
      PCRB_PUMP_SINK = 2'h2,
      PCRB_PUMP_NORMAL = 2'h3
   } pcrb_pump_mode_t;
endpackage

// [verilog/pcrb_bank.sv]
// loop configuration register bank behind the serial control port
//
// What this block does
// R1 - tag low byte at 0x005, reset zero
// R2 - tag high byte at 0x006, reset zero
// R3 - tag bytes are storage only
// R4 - bit 7 selects detector polarity, positive default
// R5 - bits 6:4 pick pump current, default 111
// R6 - bits 3:2 pick pump mode, default normal
// R7 - bits 1:0 pick loop mode, default async
// R8 - divider low byte at 0x011, reset one
// R9 - divider upper six bits at 0x012
// R10 - soft reset restores defaults, bit self-clears
// R11 - software avoids loop mode code 10
`timescale 1ns/10ps

`include "pcrb_regs.svh"

module pcrb_bank (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register access from the serial port decoder
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [9:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_ff,
   output logic rvalid_ff,
   // configuration towards the loop
   output logic [15:0] version_tag_ff,
   output logic detector_negative_ff,
   output logic [2:0] pump_current_ff,
   output pcrb_pkg::pcrb_pump_mode_t pump_mode_ff,
   output pcrb_pkg::pcrb_loop_mode_t loop_mode_ff,
   output logic loop_powered_down_ff,
   output logic [13:0] ref_divider_ff
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic soft_reset_ff;
   logic clr;
   // reset image of the loop control byte, sliced for the polarity and pump current fields
   localparam logic [7:0] loop_rst_val = `PCRB_RST_LOOP;

   // soft reset acts one cycle after its write, like a reset
   assign clr = !resetn || soft_reset_ff; // R10

   function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------
   // soft reset request
   // ----------------------------------------
   // self-clearing: held only for the cycle after the write
   always_ff @(posedge clk) begin
      if (!resetn) begin
         soft_reset_ff <= 1'b0;
      end else begin
         soft_reset_ff <= wr_en && hit(addr, `PCRB_OFS_CTRL)
                          && wdata[`PCRB_SOFT_RESET_BIT]; // R10
      end
   end

   // ----------------------------------------
   // version tag
   // ----------------------------------------
   // the tag drives nothing but its own readback
   always_ff @(posedge clk) begin
      if (clr) begin
         version_tag_ff <= {`PCRB_RST_TAG, `PCRB_RST_TAG}; // R1 R2
      end else if (wr_en && hit(addr, `PCRB_OFS_TAG_LO)) begin
         version_tag_ff[7:0] <= wdata; // R1 R3
      end else if (wr_en && hit(addr, `PCRB_OFS_TAG_HI)) begin
         version_tag_ff[15:8] <= wdata; // R2 R3
      end
   end

   // ----------------------------------------
   // loop control
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (clr) begin
         detector_negative_ff <= loop_rst_val[`PCRB_POL_BIT]; // R4
         pump_current_ff <= loop_rst_val[`PCRB_CUR_MSB:`PCRB_CUR_LSB]; // R5
         pump_mode_ff <= pcrb_pkg::PCRB_PUMP_NORMAL; // R6
         loop_mode_ff <= pcrb_pkg::PCRB_LOOP_ASYNC_PD; // R7
      end else if (wr_en && hit(addr, `PCRB_OFS_LOOP)) begin
         detector_negative_ff <= wdata[`PCRB_POL_BIT]; // R4
         pump_current_ff <= wdata[`PCRB_CUR_MSB:`PCRB_CUR_LSB]; // R5
         pump_mode_ff <= pcrb_pkg::pcrb_pump_mode_t'(
            wdata[`PCRB_PMODE_MSB:`PCRB_PMODE_LSB]); // R6
         loop_mode_ff <= pcrb_pkg::pcrb_loop_mode_t'(
            wdata[`PCRB_LMODE_MSB:`PCRB_LMODE_LSB]); // R7
      end
   end

   // anything but normal keeps the loop down; unused code is treated as down
   always_ff @(posedge clk) begin
      if (clr) begin
         loop_powered_down_ff <= 1'b1;
      end else if (wr_en && hit(addr, `PCRB_OFS_LOOP)) begin
         loop_powered_down_ff <= (wdata[1:0] != 2'h0); // R7 R11
      end
   end

   // ----------------------------------------
   // reference divider
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (clr) begin
         ref_divider_ff <= {`PCRB_RST_RDIV_HI, `PCRB_RST_RDIV_LO}; // R8 R9
      end else if (wr_en && hit(addr, `PCRB_OFS_RDIV_LO)) begin
         ref_divider_ff[7:0] <= wdata; // R8
      end else if (wr_en && hit(addr, `PCRB_OFS_RDIV_HI)) begin
         ref_divider_ff[13:8] <= wdata[5:0]; // R9
      end
   end

   // ----------------------------------------
   // readback
   // ----------------------------------------
   // unmapped offsets read zero; soft reset bit always reads zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= rd_en;
         case (addr)
            `PCRB_OFS_TAG_LO: rdata_ff <= version_tag_ff[7:0];
            `PCRB_OFS_TAG_HI: rdata_ff <= version_tag_ff[15:8];
            `PCRB_OFS_LOOP: rdata_ff <= {detector_negative_ff, pump_current_ff,
                                         pump_mode_ff, loop_mode_ff};
            `PCRB_OFS_RDIV_LO: rdata_ff <= ref_divider_ff[7:0];
            `PCRB_OFS_RDIV_HI: rdata_ff <= {2'h0, ref_divider_ff[13:8]};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   tag_isolation_a: assert property (@(posedge clk) disable iff (!resetn) // R3
      wr_en && (hit(addr, `PCRB_OFS_TAG_LO) || hit(addr, `PCRB_OFS_TAG_HI)) && !clr
      |=> $stable(loop_mode_ff) && $stable(ref_divider_ff)
          && $stable(pump_current_ff) && $stable(pump_mode_ff)
          && $stable(detector_negative_ff) && $stable(loop_powered_down_ff))
      else $error("tag write changed loop settings");

   tag_lo_write_a: assert property (@(posedge clk) disable iff (!resetn) // R1
      wr_en && hit(addr, `PCRB_OFS_TAG_LO) && !clr
      |=> version_tag_ff[7:0] == $past(wdata))
      else $error("tag low byte not stored");

   tag_hi_write_a: assert property (@(posedge clk) disable iff (!resetn) // R2
      wr_en && hit(addr, `PCRB_OFS_TAG_HI) && !clr
      |=> version_tag_ff[15:8] == $past(wdata))
      else $error("tag high byte not stored");

   loop_fields_a: assert property (@(posedge clk) disable iff (!resetn) // R4
      wr_en && hit(addr, `PCRB_OFS_LOOP) && !clr
      |=> {detector_negative_ff, pump_current_ff, pump_mode_ff, loop_mode_ff}
          == $past(wdata))
      else $error("loop control fields wrong");

   pump_current_a: assert property (@(posedge clk) disable iff (!resetn) // R5
      wr_en && hit(addr, `PCRB_OFS_LOOP) && !clr
      |=> pump_current_ff == $past(wdata[6:4]))
      else $error("pump current field wrong");

   pump_mode_a: assert property (@(posedge clk) disable iff (!resetn) // R6
      wr_en && hit(addr, `PCRB_OFS_LOOP) && !clr
      |=> pump_mode_ff == $past(wdata[3:2]))
      else $error("pump mode field wrong");

   loop_down_a: assert property (@(posedge clk) disable iff (!resetn) // R7
      loop_powered_down_ff == (loop_mode_ff != pcrb_pkg::PCRB_LOOP_NORMAL))
      else $error("power-down flag disagrees with loop mode");

   rdiv_lo_a: assert property (@(posedge clk) disable iff (!resetn) // R8
      wr_en && hit(addr, `PCRB_OFS_RDIV_LO) && !clr
      |=> ref_divider_ff[7:0] == $past(wdata))
      else $error("divider low byte not stored");

   rdiv_hi_a: assert property (@(posedge clk) disable iff (!resetn) // R9
      wr_en && hit(addr, `PCRB_OFS_RDIV_HI) && !clr
      |=> ref_divider_ff[13:8] == $past(wdata[5:0]))
      else $error("divider high bits not stored");

   sequence soft_req_s;
      wr_en && hit(addr, `PCRB_OFS_CTRL) && wdata[`PCRB_SOFT_RESET_BIT];
   endsequence

   soft_reset_a: assert property (@(posedge clk) disable iff (!resetn) // R10
      soft_req_s |=> soft_reset_ff ##1 (ref_divider_ff == 14'h0001
         && loop_mode_ff == pcrb_pkg::PCRB_LOOP_ASYNC_PD
         && version_tag_ff == 16'h0000))
      else $error("soft reset did not restore defaults");

   // the pulse may only last longer when a fresh request arrives during it
   soft_clear_a: assert property (@(posedge clk) disable iff (!resetn) // R10
      soft_reset_ff |=> !soft_reset_ff
         || $past(wr_en && hit(addr, `PCRB_OFS_CTRL) && wdata[`PCRB_SOFT_RESET_BIT]))
      else $error("soft reset bit did not clear");

   // readback: the byte at the presented offset appears one cycle later
   read_valid_a: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> rvalid_ff == $past(rd_en))
      else $error("read valid does not follow the read strobe");

   tag_read_a: assert property (@(posedge clk) disable iff (!resetn) // R1
      hit(addr, `PCRB_OFS_TAG_LO) |=> rdata_ff == $past(version_tag_ff[7:0]))
      else $error("tag low byte read back wrong");

   loop_read_a: assert property (@(posedge clk) disable iff (!resetn) // R4
      hit(addr, `PCRB_OFS_LOOP)
      |=> rdata_ff == $past({detector_negative_ff, pump_current_ff, pump_mode_ff,
                             loop_mode_ff}))
      else $error("loop control byte read back wrong");

   // reserved divider bits must never leak into the readback
   rdiv_hi_read_a: assert property (@(posedge clk) disable iff (!resetn) // R9
      hit(addr, `PCRB_OFS_RDIV_HI)
      |=> rdata_ff == {2'h0, $past(ref_divider_ff[13:8])})
      else $error("divider high byte read back wrong");

   // the request bit is write-only, so software never sees it set
   ctrl_read_a: assert property (@(posedge clk) disable iff (!resetn) // R10
      hit(addr, `PCRB_OFS_CTRL) |=> rdata_ff == 8'h00)
      else $error("control offset read back not zero");

endmodule

// [tb/pcrb_bank_bench.sv]
// self-checking bench for the loop configuration register bank
`timescale 1ns/10ps

module pcrb_bank_bench;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [9:0] addr = 10'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic [15:0] version_tag_ff;
   logic detector_negative_ff;
   logic [2:0] pump_current_ff;
   pcrb_pkg::pcrb_pump_mode_t pump_mode_ff;
   pcrb_pkg::pcrb_loop_mode_t loop_mode_ff;
   logic loop_powered_down_ff;
   logic [13:0] ref_divider_ff;
   int miscompares = 0;
   int n_checks = 0;
   // shadow of what the bank should hold
   logic [15:0] sh_tag;
   logic [7:0] sh_loop;
   logic [13:0] sh_rdiv;
   typedef struct packed {logic [9:0] a; logic [7:0] d; logic [7:0] q;} pcrb_row_t;
   // every pump current and pump mode is written; loop mode code 10 never is
   pcrb_row_t rows [14] = '{
      '{10'h005, 8'hA5, 8'hA5}, '{10'h006, 8'h3C, 8'h3C}, '{10'h010, 8'h80, 8'h80},
      '{10'h010, 8'h95, 8'h95}, '{10'h010, 8'h24, 8'h24}, '{10'h010, 8'h3B, 8'h3B},
      '{10'h010, 8'h4C, 8'h4C}, '{10'h010, 8'h5D, 8'h5D}, '{10'h010, 8'h6F, 8'h6F},
      '{10'h010, 8'h7F, 8'h7F}, '{10'h011, 8'hFF, 8'hFF}, '{10'h012, 8'hFF, 8'h3F},
      '{10'h013, 8'hAA, 8'h00}, '{10'h3FF, 8'h11, 8'h00}};

   always #50 clk = ~clk;

   pcrb_bank DUT (.clk(clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
      .version_tag_ff(version_tag_ff), .detector_negative_ff(detector_negative_ff),
      .pump_current_ff(pump_current_ff), .pump_mode_ff(pump_mode_ff),
      .loop_mode_ff(loop_mode_ff), .loop_powered_down_ff(loop_powered_down_ff),
      .ref_divider_ff(ref_divider_ff));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // strobes change at the falling edge so the rising edge sees them settled
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd_en = 1'b1;
      addr = a;
      @(negedge clk);
      rd_en = 1'b0;
      chk({15'h0000, rvalid_ff}, 16'h0001);
      chk({8'h00, rdata_ff}, {8'h00, exp});
      @(negedge clk);
      chk({15'h0000, rvalid_ff}, 16'h0000);
   endtask

   task automatic dflt;
      sh_tag = 16'h0000;
      sh_loop = 8'h7D;
      sh_rdiv = 14'h0001;
   endtask

   task automatic outs;
      chk(version_tag_ff, sh_tag);
      chk({8'h00, detector_negative_ff, pump_current_ff, pump_mode_ff, loop_mode_ff},
         {8'h00, sh_loop});
      chk({15'h0000, loop_powered_down_ff}, {15'h0000, sh_loop[1:0] != 2'b00});
      chk({2'b00, ref_divider_ff}, {2'b00, sh_rdiv});
   endtask

   task automatic stop_test;
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      dflt();
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      outs();
      rd(10'h012, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         case (rows[i].a)
            10'h005: sh_tag[7:0] = rows[i].d;
            10'h006: sh_tag[15:8] = rows[i].d;
            10'h010: sh_loop = rows[i].d;
            10'h011: sh_rdiv[7:0] = rows[i].d;
            10'h012: sh_rdiv[13:8] = rows[i].d[5:0];
            default: ;
         endcase
         outs();
         rd(rows[i].a, rows[i].q);
      end
      // back-to-back byte writes land independently
      @(negedge clk);
      wr_en = 1'b1;
      addr = 10'h011;
      wdata = 8'hC3;
      @(negedge clk);
      addr = 10'h012;
      wdata = 8'h2A;
      @(negedge clk);
      wr_en = 1'b0;
      sh_rdiv = 14'h2AC3;
      outs();
      // soft reset; a write in the pulse cycle must be lost
      // strobe held high across both writes so it is never set twice in one step
      @(negedge clk);
      wr_en = 1'b1;
      addr = 10'h000;
      wdata = 8'h20;
      @(negedge clk);
      addr = 10'h005;
      wdata = 8'h77;
      @(negedge clk);
      wr_en = 1'b0;
      @(negedge clk);
      dflt();
      outs();
      rd(10'h000, 8'h00);
      // synchronous reset in mid-run
      wr(10'h010, 8'h00);
      sh_loop = 8'h00;
      outs();
      resetn = 1'b0;
      @(negedge clk);
      resetn = 1'b1;
      dflt();
      outs();
      stop_test();
   end

   // watchdog well beyond the expected run of some 90 cycles
   initial begin
      #100000;
      miscompares++;
      stop_test();
   end
endmodule
